// file: src/hwlt_pkg.sv
`default_nettype none

package hwlt_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_COUNT   = 8'h00;
    localparam logic [7:0] OFS_PERIOD  = 8'h04;
    localparam logic [7:0] OFS_CTRL0   = 8'h08;
    localparam logic [7:0] OFS_CTRL1   = 8'h0C;
    localparam logic [7:0] OFS_FLAG    = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h14;

    // reset values
    localparam logic [7:0] RST_COUNT   = 8'h00;
    localparam logic [7:0] RST_PERIOD  = 8'hFF;

    // limit_control_0 fields
    localparam int CTRL0_PRE_LSB  = 0;
    localparam int CTRL0_ON_BIT   = 2;
    localparam int CTRL0_POST_LSB = 3;
    // limit_control_1 fields
    localparam int CTRL1_REN_BIT  = 0;
    localparam int CTRL1_FEN_BIT  = 1;
    localparam int CTRL1_SRC_LSB  = 2;
    localparam int CTRL1_RES_BIT  = 6;
    localparam int CTRL1_FES_BIT  = 7;
    localparam int FLAG_BIT       = 0;

    // timing
    localparam int         CLK_MHZ      = 125;
    localparam int         INST_DIV     = 4;
    localparam logic [1:0] INST_LAST    = 2'(INST_DIV - 1);

    // prescale terminal counts for 1:1, 1:4, 1:16, 1:64
    localparam logic [5:0] PRE_TC_1  = 6'h00;
    localparam logic [5:0] PRE_TC_4  = 6'h03;
    localparam logic [5:0] PRE_TC_16 = 6'h0F;
    localparam logic [5:0] PRE_TC_64 = 6'h3F;

    // external reset source codes
    localparam logic [2:0] SRC_CCP   = 3'h0;
    localparam logic [2:0] SRC_CMP1  = 3'h1;
    localparam logic [2:0] SRC_CMP2  = 3'h2;
    localparam logic [2:0] SRC_FAULT = 3'h3;
    localparam logic [2:0] SRC_WOUT0 = 3'h4;
    localparam logic [2:0] SRC_WOUT1 = 3'h5;

    typedef enum logic [2:0] {
        REG_COUNT  = 3'b000,
        REG_PERIOD = 3'b001,
        REG_CTRL0  = 3'b010,
        REG_CTRL1  = 3'b011,
        REG_FLAG   = 3'b100,
        REG_IRQ_EN = 3'b101,
        REG_NONE   = 3'b111
    } hwlt_reg_t;

    // selectable clearing inputs
    typedef struct packed {
        logic waveform_output_1;
        logic waveform_output_0;
        logic waveform_fault_pin;
        logic comparator_2;
        logic comparator_1;
        logic capture_compare_out;
    } hwlt_src_t;

    typedef struct packed {
        logic [1:0]  phase;
        logic [5:0]  pre;
        logic [3:0]  post;
        logic [7:0]  limit_count;
        logic [7:0]  limit_period;
        logic [3:0]  postscale_select;
        logic        timer_on;
        logic [1:0]  prescale_select;
        logic        falling_edge_sensitive;
        logic        rising_edge_sensitive;
        logic [2:0]  ext_reset_source;
        logic        falling_reset_enable;
        logic        rising_reset_enable;
        logic        limit_match_flag;
        logic        limit_match_irq_enable;
        logic        src_prev;
        logic        reset_pending;
        logic        match;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } hwlt_state_t;

endpackage

`default_nettype wire

// file: src/hwlt_top.sv
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module hwlt_top #(
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               clk_en,
    input  wire logic               soft_rst,
    input  wire logic               sleep,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // clearing sources
    input  wire hwlt_pkg::hwlt_src_t ext_src,
    // results
    output logic                    limit_match_out,
    output logic                    irq_out
);

    hwlt_pkg::hwlt_state_t st_ff;
    hwlt_pkg::hwlt_state_t nxt_st;

    function automatic hwlt_pkg::hwlt_reg_t decode(input logic [ADDR_W-1:0] a);
        logic [7:0] b;
        b = a[7:0];
        if (b == hwlt_pkg::OFS_COUNT) begin
            decode = hwlt_pkg::REG_COUNT;
        end else if (b == hwlt_pkg::OFS_PERIOD) begin
            decode = hwlt_pkg::REG_PERIOD;
        end else if (b == hwlt_pkg::OFS_CTRL0) begin
            decode = hwlt_pkg::REG_CTRL0;
        end else if (b == hwlt_pkg::OFS_CTRL1) begin
            decode = hwlt_pkg::REG_CTRL1;
        end else if (b == hwlt_pkg::OFS_FLAG) begin
            decode = hwlt_pkg::REG_FLAG;
        end else if (b == hwlt_pkg::OFS_IRQ_EN) begin
            decode = hwlt_pkg::REG_IRQ_EN;
        end else begin
            decode = hwlt_pkg::REG_NONE;
        end
    endfunction

    function automatic logic [5:0] pre_tc(input logic [1:0] sel);
        case (sel)
            2'h0:    pre_tc = hwlt_pkg::PRE_TC_1;
            2'h1:    pre_tc = hwlt_pkg::PRE_TC_4;
            2'h2:    pre_tc = hwlt_pkg::PRE_TC_16;
            default: pre_tc = hwlt_pkg::PRE_TC_64;
        endcase
    endfunction

    function automatic hwlt_pkg::hwlt_state_t reset_state();
        hwlt_pkg::hwlt_state_t s;
        s              = '0;
        s.limit_count  = hwlt_pkg::RST_COUNT;
        s.limit_period = hwlt_pkg::RST_PERIOD;
        reset_state    = s;
    endfunction

    // bus phases
    logic              access;
    logic              done;
    logic              wr;
    hwlt_pkg::hwlt_reg_t sel_reg;
    logic              wr_count;
    logic              wr_ctrl0;
    // timer clocking
    logic              inst_tick;
    logic              pre_done;
    logic              tick;
    logic              eq;
    logic              match_now;
    // external clear
    logic              src_valid;
    logic              src_now;
    logic              rise_ev;
    logic              fall_ev;

    always_comb begin
        sel_reg   = decode(paddr);
        access    = psel & penable & ~st_ff.pready;
        done      = psel & penable & st_ff.pready;
        wr        = done & pwrite;
        wr_count  = wr & (sel_reg == hwlt_pkg::REG_COUNT);
        wr_ctrl0  = wr & (sel_reg == hwlt_pkg::REG_CTRL0);

        inst_tick = (st_ff.phase == hwlt_pkg::INST_LAST) & ~sleep;
        pre_done  = st_ff.pre == pre_tc(st_ff.prescale_select);
        tick      = st_ff.timer_on & inst_tick & pre_done;
        eq        = st_ff.limit_count == st_ff.limit_period;
        match_now = tick & eq & ~st_ff.reset_pending & ~wr_count;

        src_valid = 1'b1;
        case (st_ff.ext_reset_source)
            hwlt_pkg::SRC_CCP:   src_now = ext_src.capture_compare_out;
            hwlt_pkg::SRC_CMP1:  src_now = ext_src.comparator_1;
            hwlt_pkg::SRC_CMP2:  src_now = ext_src.comparator_2;
            hwlt_pkg::SRC_FAULT: src_now = ext_src.waveform_fault_pin;
            hwlt_pkg::SRC_WOUT0: src_now = ext_src.waveform_output_0;
            hwlt_pkg::SRC_WOUT1: src_now = ext_src.waveform_output_1;
            default: begin
                src_now   = 1'b0;
                src_valid = 1'b0;
            end
        endcase
        rise_ev = src_valid & st_ff.rising_reset_enable
                & (st_ff.rising_edge_sensitive ? src_now & ~st_ff.src_prev : src_now);
        fall_ev = src_valid & st_ff.falling_reset_enable
                & (st_ff.falling_edge_sensitive ? ~src_now & st_ff.src_prev : ~src_now);
    end

    always_comb begin
        nxt_st = st_ff;

        // instruction clock phase
        nxt_st.phase = st_ff.phase + 2'h1;
        if (sleep) begin
            nxt_st.phase = st_ff.phase;
        end

        // prescaler
        if (st_ff.timer_on & inst_tick) begin
            nxt_st.pre = pre_done ? 6'h00 : st_ff.pre + 6'h01;
        end

        // external clear capture; new events win over tick consumption
        nxt_st.src_prev      = src_now;
        nxt_st.reset_pending = rise_ev | fall_ev | (st_ff.reset_pending & ~tick);

        // count
        nxt_st.match = match_now;
        if (tick) begin
            if (st_ff.reset_pending) begin
                nxt_st.limit_count = 8'h00;
            end else if (eq) begin
                nxt_st.limit_count = 8'h00;
            end else begin
                nxt_st.limit_count = st_ff.limit_count + 8'h01;
            end
        end

        // postscaler and flag, set beats clear
        if (wr & (sel_reg == hwlt_pkg::REG_FLAG) & ~pwdata[hwlt_pkg::FLAG_BIT]) begin
            nxt_st.limit_match_flag = 1'b0;
        end
        if (match_now) begin
            if (st_ff.post == st_ff.postscale_select) begin
                nxt_st.post             = 4'h0;
                nxt_st.limit_match_flag = 1'b1;
            end else begin
                nxt_st.post = st_ff.post + 4'h1;
            end
        end
        nxt_st.irq = st_ff.limit_match_flag & st_ff.limit_match_irq_enable;

        // register writes at the completing edge
        if (wr) begin
            if (sel_reg == hwlt_pkg::REG_COUNT) begin
                nxt_st.limit_count   = pwdata[7:0];
                nxt_st.reset_pending = 1'b0;
                nxt_st.pre           = 6'h00;
                nxt_st.post          = 4'h0;
            end else if (sel_reg == hwlt_pkg::REG_PERIOD) begin
                nxt_st.limit_period = pwdata[7:0];
            end else if (sel_reg == hwlt_pkg::REG_CTRL0) begin
                nxt_st.prescale_select  = pwdata[hwlt_pkg::CTRL0_PRE_LSB +: 2];
                nxt_st.timer_on         = pwdata[hwlt_pkg::CTRL0_ON_BIT];
                nxt_st.postscale_select = pwdata[hwlt_pkg::CTRL0_POST_LSB +: 4];
                nxt_st.pre              = 6'h00;
                nxt_st.post             = 4'h0;
            end else if (sel_reg == hwlt_pkg::REG_CTRL1) begin
                nxt_st.rising_reset_enable    = pwdata[hwlt_pkg::CTRL1_REN_BIT];
                nxt_st.falling_reset_enable   = pwdata[hwlt_pkg::CTRL1_FEN_BIT];
                nxt_st.ext_reset_source       = pwdata[hwlt_pkg::CTRL1_SRC_LSB +: 3];
                nxt_st.rising_edge_sensitive  = pwdata[hwlt_pkg::CTRL1_RES_BIT];
                nxt_st.falling_edge_sensitive = pwdata[hwlt_pkg::CTRL1_FES_BIT];
            end else if (sel_reg == hwlt_pkg::REG_IRQ_EN) begin
                nxt_st.limit_match_irq_enable = pwdata[hwlt_pkg::FLAG_BIT];
            end
        end

        // apb answer, one wait state
        nxt_st.pready  = access;
        nxt_st.pslverr = access & (sel_reg == hwlt_pkg::REG_NONE);
        if (access) begin
            nxt_st.prdata = 32'h0000_0000;
            if (sel_reg == hwlt_pkg::REG_COUNT) begin
                nxt_st.prdata[7:0] = st_ff.limit_count;
            end else if (sel_reg == hwlt_pkg::REG_PERIOD) begin
                nxt_st.prdata[7:0] = st_ff.limit_period;
            end else if (sel_reg == hwlt_pkg::REG_CTRL0) begin
                nxt_st.prdata[6:0] = {st_ff.postscale_select, st_ff.timer_on,
                                      st_ff.prescale_select};
            end else if (sel_reg == hwlt_pkg::REG_CTRL1) begin
                nxt_st.prdata[7:0] = {st_ff.falling_edge_sensitive,
                                      st_ff.rising_edge_sensitive, 1'b0,
                                      st_ff.ext_reset_source,
                                      st_ff.falling_reset_enable,
                                      st_ff.rising_reset_enable};
            end else if (sel_reg == hwlt_pkg::REG_FLAG) begin
                nxt_st.prdata[hwlt_pkg::FLAG_BIT] = st_ff.limit_match_flag;
            end else if (sel_reg == hwlt_pkg::REG_IRQ_EN) begin
                nxt_st.prdata[hwlt_pkg::FLAG_BIT] = st_ff.limit_match_irq_enable;
            end
        end

        // reset instruction acts like any device reset
        if (soft_rst) begin
            nxt_st = reset_state();
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= reset_state();
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        prdata          = st_ff.prdata;
        pready          = st_ff.pready;
        pslverr         = st_ff.pslverr;
        limit_match_out = st_ff.match;
        irq_out         = st_ff.irq;
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic run;
    assign run = clk_en & ~soft_rst;

    property p_match_clear;
        run && match_now |=> st_ff.limit_count == 8'h00 && limit_match_out;
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("match did not clear");

    property p_ext_clear;
        run && tick && st_ff.reset_pending && !wr_count
            |=> st_ff.limit_count == 8'h00 && !limit_match_out;
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("external clear missed");

    property p_wr_count;
        run && wr_count |=> st_ff.limit_count == $past(pwdata[7:0])
            && !st_ff.reset_pending && st_ff.pre == 6'h00 && st_ff.post == 4'h0;
    endproperty
    a_wr_count: assert property (p_wr_count) else $error("count write lost");

    property p_ctrl0_keep;
        run && wr_ctrl0 && !tick |=> $stable(st_ff.limit_count) && st_ff.pre == 6'h00;
    endproperty
    a_ctrl0_keep: assert property (p_ctrl0_keep) else $error("control write moved count");

    property p_off_hold;
        run && !st_ff.timer_on && !wr |=> $stable(st_ff.limit_count)
            && $stable(st_ff.pre) && !limit_match_out;
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("timer ran while off");

    property p_sleep_hold;
        run && sleep && !wr |=> $stable(st_ff.limit_count);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");

    property p_post_flag;
        run && match_now && st_ff.post == st_ff.postscale_select |=> st_ff.limit_match_flag;
    endproperty
    a_post_flag: assert property (p_post_flag) else $error("flag not set");

    property p_irq;
        run |=> irq_out == ($past(st_ff.limit_match_flag) && $past(st_ff.limit_match_irq_enable));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch");

    property p_count_tick;
        run && !tick && !wr_count |=> $stable(st_ff.limit_count);
    endproperty
    a_count_tick: assert property (p_count_tick) else $error("count moved off tick");

    property p_pre_range;
        st_ff.pre <= pre_tc(st_ff.prescale_select);
    endproperty
    a_pre_range: assert property (p_pre_range) else $error("prescaler past limit");

    property p_ctrl0_clr;
        run && wr_ctrl0 |=> st_ff.pre == 6'h00 && st_ff.post == 4'h0;
    endproperty
    a_ctrl0_clr: assert property (p_ctrl0_clr) else $error("scalers not cleared");

    property p_level_arm;
        run && st_ff.rising_reset_enable && !st_ff.rising_edge_sensitive
            && src_valid && src_now && !wr_count |=> st_ff.reset_pending;
    endproperty
    a_level_arm: assert property (p_level_arm) else $error("level clear lost");

    property p_off_flag;
        run && !st_ff.timer_on && !wr
            |=> $stable(st_ff.post) && $stable(st_ff.limit_match_flag);
    endproperty
    a_off_flag: assert property (p_off_flag) else $error("scaler moved while off");

    property p_apb;
        clk_en && !soft_rst && access |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer late");

    c_match: cover property (limit_match_out);
    c_flag:  cover property (run && match_now && st_ff.postscale_select == 4'hF);
    c_ext:   cover property (run && tick && st_ff.reset_pending);
    c_race:  cover property (wr_count && (rise_ev || fall_ev));

endmodule

`default_nettype wire

// file: test/hwlt_far_end.sv
`timescale 1ns/1ps
`default_nettype none

module hwlt_far_end (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // commands from the bench
    input  wire logic [2:0]     sel,
    input  wire logic           hold,
    input  wire logic           go,
    input  wire logic [7:0]     len,
    // block side
    input  wire logic           limit_match_out,
    output hwlt_pkg::hwlt_src_t ext_src,
    output logic [15:0]         match_cnt
);
    logic [7:0]  left_ff;
    logic [15:0] cnt_ff;
    logic [5:0]  lines;

    // pulse length counter and match tally
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_ff <= 8'h00;
            cnt_ff  <= 16'h0000;
        end else begin
            if (go) begin
                left_ff <= len;
            end else if (left_ff != 8'h00) begin
                left_ff <= left_ff - 8'h01;
            end
            if (limit_match_out) begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end

    // selected source moves; reserved codes move every line
    always_comb begin
        lines = 6'h00;
        if (sel < 3'h6) begin
            lines[sel] = hold | (left_ff != 8'h00);
        end else begin
            lines = {6{hold | (left_ff != 8'h00)}};
        end
    end

    assign ext_src   = hwlt_pkg::hwlt_src_t'(lines);
    assign match_cnt = cnt_ff;
endmodule

`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                soft_rst = 1'b0;
    logic                sleep = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [7:0]          paddr = 8'h00;
    logic [31:0]         pwdata = 32'h0;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    hwlt_pkg::hwlt_src_t ext_src;
    logic                limit_match_out;
    logic                irq_out;
    logic [2:0]          f_sel = 3'h0;
    logic                f_hold = 1'b0;
    logic                f_go = 1'b0;
    logic [7:0]          f_len = 8'h00;
    logic [15:0]         match_cnt;
    int                  n_fail = 0;
    int                  n_compared = 0;

    always #4 clk = ~clk;

    hwlt_top u_hwlt_top (
        .clk(clk), .rst(rst), .clk_en(1'b1), .soft_rst(soft_rst), .sleep(sleep),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_src(ext_src), .limit_match_out(limit_match_out), .irq_out(irq_out)
    );

    hwlt_far_end u_hwlt_far_end (
        .clk(clk), .rst(rst), .sel(f_sel), .hold(f_hold), .go(f_go), .len(f_len),
        .limit_match_out(limit_match_out), .ext_src(ext_src), .match_cnt(match_cnt)
    );

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask

    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // setup, access, then hold until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        chk(k < 20, "no pready");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    // cycles between two later match pulses
    task automatic gap(output int g);
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            g = 1;
            while (limit_match_out !== 1'b1 && g < 4000) begin
                @(negedge clk);
                g++;
            end
        end
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        rd(hwlt_pkg::OFS_COUNT, r);
        chk(r === 32'h00, "count reset");
        rd(hwlt_pkg::OFS_PERIOD, r);
        chk(r === 32'hFF, "period reset");
        wr(hwlt_pkg::OFS_PERIOD, 32'h37);
        wr(hwlt_pkg::OFS_COUNT, 32'h21);
        rd(hwlt_pkg::OFS_PERIOD, r);
        chk(r === 32'h37, "period rw");
        rd(hwlt_pkg::OFS_COUNT, r);
        chk(r === 32'h21, "count rw");
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk(e === 1'b1, "unmapped");
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        rd(hwlt_pkg::OFS_COUNT, r);
        chk(r === 32'h00, "count soft reset");
        rd(hwlt_pkg::OFS_PERIOD, r);
        chk(r === 32'hFF, "period soft reset");
        $display("test reset done");
    endtask

    task automatic t_prescale();
        int g;
        wr(hwlt_pkg::OFS_PERIOD, 32'h2);
        for (int p = 0; p < 4; p++) begin
            wr(hwlt_pkg::OFS_CTRL0, 32'(4 + p));
            gap(g);
            chk(g == 12 * (1 << (2 * p)), "match spacing");
        end
        $display("test prescale done");
    endtask

    task automatic t_post();
        int          n;
        int          cd [3] = '{0, 5, 15};
        logic [31:0] r;
        wr(hwlt_pkg::OFS_IRQ_EN, 32'h1);
        wr(hwlt_pkg::OFS_PERIOD, 32'h0);
        wr(hwlt_pkg::OFS_COUNT, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(hwlt_pkg::OFS_CTRL0, 32'h0);
            wr(hwlt_pkg::OFS_FLAG, 32'h0);
            wr(hwlt_pkg::OFS_CTRL0, 32'(cd[i] * 8 + 4));
            n = 0;
            for (int k = 0; k < 300 && irq_out !== 1'b1; k++) begin
                @(negedge clk);
                if (limit_match_out === 1'b1) n++;
            end
            chk(n == cd[i] + 1, "postscale ratio");
        end
        wr(hwlt_pkg::OFS_IRQ_EN, 32'h0);
        repeat (2) @(posedge clk);
        rd(hwlt_pkg::OFS_FLAG, r);
        chk(r === 32'h1, "flag set");
        chk(irq_out === 1'b0, "masked irq");
        $display("test postscale done");
    endtask

    task automatic t_off();
        logic [31:0] r;
        logic [15:0] m;
        wr(hwlt_pkg::OFS_CTRL0, 32'h0);
        wr(hwlt_pkg::OFS_PERIOD, 32'h5);
        wr(hwlt_pkg::OFS_COUNT, 32'h5);
        m = match_cnt;
        repeat (200) @(posedge clk);
        rd(hwlt_pkg::OFS_COUNT, r);
        chk(r === 32'h5, "count held off");
        chk(match_cnt === m, "match while off");
        wr(hwlt_pkg::OFS_PERIOD, 32'hFF);
        wr(hwlt_pkg::OFS_CTRL0, 32'h7);
        wr(hwlt_pkg::OFS_COUNT, 32'h40);
        wr(hwlt_pkg::OFS_CTRL0, 32'h7);
        rd(hwlt_pkg::OFS_COUNT, r);
        chk(r === 32'h40, "control write kept count");
        $display("test off done");
    endtask

    task automatic t_sleep();
        logic [31:0] c1;
        logic [31:0] c2;
        wr(hwlt_pkg::OFS_CTRL0, 32'h4);
        sleep <= 1'b1;
        rd(hwlt_pkg::OFS_COUNT, c1);
        repeat (100) @(posedge clk);
        rd(hwlt_pkg::OFS_COUNT, c2);
        chk(c1 === c2, "count moved in sleep");
        sleep <= 1'b0;
        repeat (40) @(posedge clk);
        rd(hwlt_pkg::OFS_COUNT, c1);
        chk(c1 !== c2, "count stuck after sleep");
        $display("test sleep done");
    endtask

    task automatic ext_try(input logic [7:0] c1, input logic [2:0] s, input bit clr);
        logic [31:0] r;
        wr(hwlt_pkg::OFS_CTRL1, {24'h0, c1});
        wr(hwlt_pkg::OFS_COUNT, 32'h80);
        f_sel <= s;
        f_go <= 1'b1;
        f_len <= 8'h03;
        @(posedge clk);
        f_go <= 1'b0;
        repeat (16) @(posedge clk);
        rd(hwlt_pkg::OFS_COUNT, r);
        if (clr) chk(r < 32'h10, "no clear");
        else chk(r >= 32'h80, "spurious clear");
    endtask

    task automatic t_ext();
        wr(hwlt_pkg::OFS_PERIOD, 32'hFF);
        for (int s = 0; s < 8; s++) ext_try(8'hC1 | 8'(s << 2), 3'(s), s < 6);
        ext_try(8'hC0, 3'h1, 1'b0);
        ext_try(8'hCA, 3'h2, 1'b1);
        $display("test external clear done");
    endtask

    task automatic t_level();
        logic [31:0] r;
        logic [15:0] m;
        wr(hwlt_pkg::OFS_PERIOD, 32'h2);
        wr(hwlt_pkg::OFS_CTRL1, 32'h01);
        f_sel <= 3'h0;
        f_hold <= 1'b1;
        repeat (8) @(posedge clk);
        m = match_cnt;
        repeat (100) @(posedge clk);
        chk(match_cnt === m, "match under level clear");
        rd(hwlt_pkg::OFS_COUNT, r);
        chk(r === 32'h0, "count not held");
        wr(hwlt_pkg::OFS_CTRL1, 32'h41);
        m = match_cnt;
        repeat (60) @(posedge clk);
        chk(match_cnt !== m, "edge mode held count");
        f_hold <= 1'b0;
        wr(hwlt_pkg::OFS_CTRL1, 32'h02);
        repeat (8) @(posedge clk);
        m = match_cnt;
        repeat (60) @(posedge clk);
        chk(match_cnt === m, "match under falling level");
        rd(hwlt_pkg::OFS_COUNT, r);
        chk(r === 32'h0, "count not held low");
        $display("test level done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_prescale();
        t_post();
        t_off();
        t_sleep();
        t_ext();
        t_level();
        conclude();
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        $display("CHECK FAILED t=%0t watchdog", $time);
        conclude();
    end
endmodule

`default_nettype wire
